// ---- src/tdc_pkg.sv ----
// Shared constants and types for the time digitizer readout block
package tdc_pkg;
   localparam int CLK_NS = 10;
   // Mode register fields, zero-based bit positions
   localparam int MB_CHTAG_DIS = 9;
   localparam int MB_FRONT = 10;
   localparam int MB_RANGE_DIS = 11;
   localparam int MB_SPARSE = 12;
   localparam int MB_SEQ = 13;
   localparam int MB_ATTN = 14;
   localparam logic [15:0] MODE_INIT_SET = 16'hFE00;
   localparam logic [15:0] MODE_RD_MASK = 16'h7EFF;
   localparam logic [15:0] MODE_RESET = 16'hFE00;
   // Data word layout
   localparam int WORD_OVF_BIT = 15;
   localparam int WORD_TAG_LSB = 12;
   localparam logic [11:0] OVF_LIMIT = 12'hF00;
   localparam int NUM_CH = 8;
   // Dataway function and subaddress codes
   localparam logic [4:0] F_RD_DATA = 5'h00;
   localparam logic [4:0] F_RD_CLR = 5'h02;
   localparam logic [4:0] F_RD_MODE = 5'h04;
   localparam logic [4:0] F_TEST_LAM = 5'h08;
   localparam logic [4:0] F_CLEAR = 5'h09;
   localparam logic [4:0] F_CLR_LAM = 5'h0A;
   localparam logic [4:0] F_WR_MODE = 5'h14;
   localparam logic [4:0] F_TEST = 5'h19;
   localparam logic [3:0] SA_ZERO = 4'h0;
   localparam logic [3:0] SA_LAST = 4'h7;
   localparam logic [3:0] SA_MODE = 4'hE;
   // Times in ns and derived cycle counts
   localparam int FULL_SCALE_NS = 200;
   localparam int CONV_DELAY_NS = 1000;
   localparam int TEST_STOP_NS = 100;
   localparam int CLEAR_NS = 1200;
   localparam int STB_SETUP_NS = 10;
   localparam int STB_WIDTH_NS = 40;
   localparam int ACK_GAP_NS = 50;
   localparam int STB_LOW_NS = 60;
   localparam int FS_CYC = (FULL_SCALE_NS + CONV_DELAY_NS + CLK_NS - 1) / CLK_NS;
   localparam int STOP_CYC = TEST_STOP_NS / CLK_NS;
   localparam int CLR_CYC = (CLEAR_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETUP_CYC = (STB_SETUP_NS + CLK_NS - 1) / CLK_NS;
   localparam int HI_CYC = STB_WIDTH_NS / CLK_NS + 1;
   localparam int LOW_NS = (STB_LOW_NS > ACK_GAP_NS) ? STB_LOW_NS : ACK_GAP_NS;
   localparam int LOW_CYC = (LOW_NS + CLK_NS - 1) / CLK_NS;

   typedef struct packed {
      logic n;
      logic [4:0] f;
      logic [3:0] a;
      logic s1;
      logic s2;
      logic z;
      logic c;
      logic inh;
      logic [15:0] w;
   } tdc_camac_cmd_t;

   typedef struct packed {
      logic [15:0] r;
      logic q;
      logic x;
   } tdc_camac_rsp_t;

   typedef enum logic [2:0] {ST_IDLE, ST_FULLSCALE, ST_CONVERT, ST_WAITCONV, ST_READOUT, ST_CLEARING} tdc_state_t;
   typedef enum logic [2:0] {E_OFF, E_WAIT, E_SETUP, E_HIGH, E_LOW, E_DONE} tdc_ecl_t;
endpackage : tdc_pkg

// ---- src/tdc_sync.sv ----
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module tdc_sync #(
   parameter int W = 4
) (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta;

   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk_i) begin
         if (srst_i) begin
            meta[i] <= 1'b0;
            sync_o[i] <= 1'b0;
         end else begin
            meta[i] <= async_i[i];
            sync_o[i] <= meta[i];
         end
      end
   end
endmodule : tdc_sync

// ---- src/tdc_readout.sv ----
// Mode register, conversion sequencing and chained front-bus readout
// What this block does
// - Test command only accepted when idle
// - Codes 3840 and above flag overflow
// - Range flag disable zeroes word bit
// - Channel tag disable zeroes bits
// - Front bus select picks one output port in sequential mode
// - Sequential sparse converts only in-window channels
// - Sequential non-sparse converts all eight channels
// - Addressed mode: subaddress selects channel word
// - LAM only when enabled and data waits
// - Mode register access only while idle
// - Initialize sets keeps module tag
// - Low byte holds module tag
// - Busy held until a clear releases it
// - Strobe after setup, wider than 40 ns
// - Pending flag until last word or clear
// - Next strobe at least 50 ns after ack
// - Grant enables outputs while data pending
// - Grant passes when nothing pending
// - Strobe, await ack, low 60 ns, next word
// - Raise pending only after grant falls
// - Held ack blocks the next strobe
// - Sequential dataway read advances pointer
// - Word holds code, channel, overflow bit
`timescale 1ns/1ps
module tdc_readout
   import tdc_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire tdc_camac_cmd_t camac_i,
   output tdc_camac_rsp_t camac_o,
   output logic lam_o,
   output logic busy_o,
   input wire logic start_i,
   input wire logic clear_i,
   output logic chan_start_o,
   output logic common_stop_o,
   input wire logic [7:0] hit_mask_i,
   output logic conv_start_o,
   output logic [2:0] conv_chan_o,
   input wire logic conv_done_i,
   input wire logic [11:0] conv_code_i,
   output logic [15:0] ecl_data_o,
   output logic ecl_oe_o,
   output logic word_strobe_o,
   input wire logic word_taken_ack_i,
   output logic data_pending_flag_o,
   input wire logic chain_grant_in_i,
   output logic chain_grant_out_o
);
   logic [3:0] sync_q;
   logic grant_s, ack_s, start_s, clr_s;
   logic start_d, clr_d;
   logic [15:0] mode;
   tdc_state_t state;
   tdc_ecl_t estate;
   logic [7:0] timer;
   logic [7:0] etmr;
   logic [2:0] ch;
   logic [3:0] cnt;
   logic [2:0] rd_ptr;
   logic [2:0] e_ptr;
   logic test_run;
   logic lam_blocked;
   logic [15:0] mem [NUM_CH];
   logic idle, rd_cmd, acc_test, acc_wr_mode, acc_rd_mode;
   logic ext_clear, int_clear, any_clear, start_ev;
   logic ecl_sel, cam_path, seq_rd, adr_rd, skip_ch, last_ch;
   logic [15:0] next_word;
   tdc_camac_rsp_t next_rsp;

   tdc_sync #(.W(4)) u_sync (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .async_i({chain_grant_in_i, word_taken_ack_i, start_i, clear_i}),
      .sync_o(sync_q)
   );
   assign {grant_s, ack_s, start_s, clr_s} = sync_q;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         start_d <= 1'b0;
         clr_d <= 1'b0;
      end else begin
         start_d <= start_s;
         clr_d <= clr_s;
      end
   end

   assign idle = (state == ST_IDLE);
   assign ecl_sel = mode[MB_FRONT] & mode[MB_SEQ];
   assign cam_path = (state == ST_READOUT) & ~ecl_sel;
   assign rd_cmd = camac_i.n & ((camac_i.f == F_RD_DATA) | (camac_i.f == F_RD_CLR));
   assign acc_test = camac_i.n & (camac_i.f == F_TEST) & (camac_i.a == SA_ZERO) & idle;
   assign acc_wr_mode = camac_i.n & (camac_i.f == F_WR_MODE) & (camac_i.a == SA_MODE) & idle;
   assign acc_rd_mode = camac_i.n & (camac_i.f == F_RD_MODE) & (camac_i.a == SA_MODE) & idle;
   assign seq_rd = rd_cmd & cam_path & mode[MB_SEQ] & (camac_i.a == SA_ZERO);
   assign adr_rd = rd_cmd & cam_path & ~mode[MB_SEQ] & (camac_i.a <= SA_LAST);
   assign ext_clear = (camac_i.s2 & (camac_i.z | camac_i.c))
      | (camac_i.n & camac_i.s2 & (camac_i.f == F_CLEAR) & (camac_i.a == SA_ZERO))
      | (clr_s & ~clr_d);
   // Internal clear: last sequential word, addressed clear-read of the last subaddress, front bus done
   assign int_clear = (seq_rd & camac_i.s2 & ({1'b0, rd_ptr} == cnt - 4'h1))
      | (adr_rd & camac_i.s2 & (camac_i.f == F_RD_CLR) & (camac_i.a == SA_LAST))
      | (estate == E_DONE);
   assign any_clear = ext_clear | int_clear;
   // Test pulse only on S2, so a bare F25 address phase never starts a cycle
   assign start_ev = (start_s & ~start_d & ~camac_i.inh) | (acc_test & camac_i.s2);
   assign skip_ch = mode[MB_SEQ] & mode[MB_SPARSE] & ~hit_mask_i[ch];
   assign last_ch = (ch == 3'h7);

   always_comb begin
      next_word[11:0] = conv_code_i;
      next_word[14:WORD_TAG_LSB] = mode[MB_CHTAG_DIS] ? 3'h0 : ch;
      next_word[WORD_OVF_BIT] = ~mode[MB_RANGE_DIS] & (conv_code_i >= OVF_LIMIT);
   end

   // Mode register: Z sets the control bits, other clears leave it alone
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         mode <= MODE_RESET;
      end else if (camac_i.z & camac_i.s2) begin
         mode <= mode | MODE_INIT_SET;
      end else if (acc_wr_mode & camac_i.s1) begin
         mode <= camac_i.w;
      end
   end

   // Acquisition sequencer
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state <= ST_IDLE;
         timer <= 8'h00;
         ch <= 3'h0;
         cnt <= 4'h0;
         busy_o <= 1'b0;
         test_run <= 1'b0;
         chan_start_o <= 1'b0;
         common_stop_o <= 1'b0;
         conv_start_o <= 1'b0;
         conv_chan_o <= 3'h0;
      end else begin
         chan_start_o <= 1'b0;
         common_stop_o <= 1'b0;
         conv_start_o <= 1'b0;
         if (any_clear && state != ST_IDLE) begin
            state <= ST_CLEARING;
            busy_o <= 1'b0;
            timer <= 8'h00;
            test_run <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (start_ev) begin
                     state <= ST_FULLSCALE;
                     chan_start_o <= 1'b1;
                     test_run <= acc_test & camac_i.s2;
                     timer <= 8'h00;
                  end
               end
               ST_FULLSCALE: begin
                  timer <= timer + 8'h01;
                  if (test_run && timer == 8'(STOP_CYC)) begin
                     common_stop_o <= 1'b1;
                  end
                  if (timer == 8'(FS_CYC - 1)) begin
                     state <= ST_CONVERT;
                     busy_o <= 1'b1;
                     ch <= 3'h0;
                     cnt <= 4'h0;
                  end
               end
               ST_CONVERT: begin
                  if (!skip_ch) begin
                     conv_start_o <= 1'b1;
                     conv_chan_o <= ch;
                     state <= ST_WAITCONV;
                  end else if (!last_ch) begin
                     ch <= ch + 3'h1;
                  end else begin
                     // Nothing valid: internal clear, busy drops
                     state <= (cnt == 4'h0) ? ST_CLEARING : ST_READOUT;
                     busy_o <= (cnt != 4'h0);
                     timer <= 8'h00;
                  end
               end
               ST_WAITCONV: begin
                  if (conv_done_i) begin
                     cnt <= cnt + 4'h1;
                     if (last_ch) begin
                        state <= ST_READOUT;
                     end else begin
                        ch <= ch + 3'h1;
                        state <= ST_CONVERT;
                     end
                  end
               end
               ST_READOUT: begin
                  // Held until a clear, internal or external
               end
               ST_CLEARING: begin
                  timer <= timer + 8'h01;
                  if (timer == 8'(CLR_CYC - 1)) begin
                     state <= ST_IDLE;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

   // Word store: sequential modes pack densely, addressed mode by channel
   always_ff @(posedge core_clk_i) begin
      if (state == ST_WAITCONV && conv_done_i) begin
         mem[mode[MB_SEQ] ? cnt[2:0] : ch] <= next_word;
      end
   end

   // Dataway readout pointer
   always_ff @(posedge core_clk_i) begin
      if (srst_i || state != ST_READOUT) begin
         rd_ptr <= 3'h0;
      end else if (seq_rd && camac_i.s2) begin
         rd_ptr <= rd_ptr + 3'h1;
      end
   end

   // Dataway answer, registered
   always_comb begin
      next_rsp = '0;
      next_rsp.x = camac_i.n;
      if (acc_rd_mode) begin
         next_rsp.r = mode & MODE_RD_MASK;
         next_rsp.q = 1'b1;
      end else if (acc_wr_mode || acc_test) begin
         next_rsp.q = 1'b1;
      end else if (seq_rd) begin
         next_rsp.r = mem[rd_ptr];
         next_rsp.q = 1'b1;
      end else if (adr_rd) begin
         next_rsp.r = mem[camac_i.a[2:0]];
         next_rsp.q = 1'b1;
      end else if (camac_i.n && camac_i.f == F_TEST_LAM) begin
         next_rsp.q = lam_o;
      end else if (camac_i.n && (camac_i.f == F_CLEAR || camac_i.f == F_CLR_LAM)) begin
         next_rsp.q = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         camac_o <= '0;
      end else begin
         camac_o <= next_rsp;
      end
   end

   // LAM: only for dataway readout; explicit LAM clear holds it off
   always_ff @(posedge core_clk_i) begin
      if (srst_i || state != ST_READOUT) begin
         lam_blocked <= 1'b0;
         lam_o <= 1'b0;
      end else begin
         if (camac_i.n && camac_i.s2 && camac_i.f == F_CLR_LAM) begin
            lam_blocked <= 1'b1;
         end
         lam_o <= mode[MB_ATTN] & cam_path & ~lam_blocked & ~any_clear;
      end
   end

   // Front bus handshake; ack is seen two cycles late, which only lengthens gaps
   always_ff @(posedge core_clk_i) begin
      if (srst_i || ext_clear || state != ST_READOUT || !ecl_sel) begin
         estate <= E_OFF;
         etmr <= 8'h00;
         e_ptr <= 3'h0;
         word_strobe_o <= 1'b0;
         data_pending_flag_o <= 1'b0;
         ecl_data_o <= 16'h0000;
      end else begin
         case (estate)
            E_OFF: begin
               if (!grant_s) begin
                  estate <= E_WAIT;
                  data_pending_flag_o <= 1'b1;
               end
            end
            E_WAIT: begin
               if (grant_s) begin
                  estate <= E_SETUP;
                  ecl_data_o <= mem[e_ptr];
                  etmr <= 8'h00;
               end
            end
            E_SETUP: begin
               etmr <= etmr + 8'h01;
               if (etmr >= 8'(SETUP_CYC) && !ack_s) begin
                  word_strobe_o <= 1'b1;
                  estate <= E_HIGH;
                  etmr <= 8'h00;
               end
            end
            E_HIGH: begin
               if (etmr != 8'hFF) begin
                  etmr <= etmr + 8'h01;
               end
               // Data stays put while strobe is high; no ack keeps the word
               if (etmr >= 8'(HI_CYC - 1) && ack_s) begin
                  word_strobe_o <= 1'b0;
                  etmr <= 8'h00;
                  if ({1'b0, e_ptr} == cnt - 4'h1) begin
                     estate <= E_DONE;
                     data_pending_flag_o <= 1'b0;
                  end else begin
                     estate <= E_LOW;
                     e_ptr <= e_ptr + 3'h1;
                  end
               end
            end
            E_LOW: begin
               if (etmr == 8'h00) begin
                  ecl_data_o <= mem[e_ptr];
               end
               if (etmr != 8'hFF) begin
                  etmr <= etmr + 8'h01;
               end
               if (etmr >= 8'(LOW_CYC - 1) && !ack_s) begin
                  word_strobe_o <= 1'b1;
                  estate <= E_HIGH;
                  etmr <= 8'h00;
               end
            end
            E_DONE: estate <= E_DONE;
            default: estate <= E_OFF;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         chain_grant_out_o <= 1'b0;
         ecl_oe_o <= 1'b0;
      end else begin
         chain_grant_out_o <= grant_s & ~data_pending_flag_o;
         ecl_oe_o <= grant_s & data_pending_flag_o;
      end
   end

   a_strobe_high: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $rose(word_strobe_o) |=> word_strobe_o [*4])
      else $error("word strobe shorter than minimum width");
   a_strobe_low: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $fell(word_strobe_o) |=> !word_strobe_o [*5])
      else $error("word strobe low period too short");
   a_ack_blocks: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $rose(word_strobe_o) |-> !$past(ack_s))
      else $error("strobe raised while acknowledge held");
   a_ovf_masked: assert property (@(posedge core_clk_i) disable iff (srst_i)
      word_strobe_o && mode[MB_RANGE_DIS] |-> !ecl_data_o[WORD_OVF_BIT])
      else $error("overflow bit set while disabled");
   a_tag_masked: assert property (@(posedge core_clk_i) disable iff (srst_i)
      word_strobe_o && mode[MB_CHTAG_DIS] |-> ecl_data_o[14:12] == 3'h0)
      else $error("channel tag present while disabled");
   a_lam_off: assert property (@(posedge core_clk_i) disable iff (srst_i)
      !mode[MB_ATTN] ##1 !mode[MB_ATTN] |-> !lam_o)
      else $error("LAM raised while disabled");
   a_grant_block: assert property (@(posedge core_clk_i) disable iff (srst_i)
      data_pending_flag_o && $past(data_pending_flag_o) |-> !chain_grant_out_o)
      else $error("grant passed while data pending");
   a_mode_idle: assert property (@(posedge core_clk_i) disable iff (srst_i)
      mode != $past(mode) |-> $past(state) == ST_IDLE || $past(camac_i.z && camac_i.s2))
      else $error("mode register changed outside idle");
   a_test_refused: assert property (@(posedge core_clk_i) disable iff (srst_i)
      camac_i.n && camac_i.f == F_TEST && camac_i.a == SA_ZERO && state != ST_IDLE |=> !camac_o.q)
      else $error("test command answered with Q outside idle");
   a_busy_clear: assert property (@(posedge core_clk_i) disable iff (srst_i)
      $fell(busy_o) |-> state == ST_CLEARING)
      else $error("busy released without a clear");
endmodule : tdc_readout

// ---- bench/tdc_ecl_driver.sv ----
// Chain readout driver model: grants while a module is pending, acknowledges each strobe
`timescale 1ns/1ps
module tdc_ecl_driver (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic slow_i,
   input wire logic hold_i,
   input wire logic word_strobe_i,
   input wire logic pending_i,
   input wire logic grant_out_i,
   output logic grant_o,
   output logic ack_o
);
   logic gnt;
   logic stb_q;
   logic [1:0] st;
   logic [4:0] cnt;
   logic [4:0] gap;
   // Hold keeps the grant up with nothing pending, so the chain passes it on
   assign grant_o = gnt | hold_i;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         gnt <= 1'b0;
         ack_o <= 1'b0;
         stb_q <= 1'b0;
         st <= 2'h0;
         cnt <= 5'h00;
         gap <= 5'h00;
      end else begin
         // Grant stays up until the pass comes back, so the whole readout is covered
         gnt <= pending_i | (gnt & !grant_out_i);
         stb_q <= word_strobe_i;
         gap <= (gap != 5'h00) ? gap - 5'h01 : gap;
         cnt <= (cnt != 5'h00) ? cnt - 5'h01 : cnt;
         case (st)
            2'h0: if (word_strobe_i && !stb_q) begin
               st <= 2'h1;
               cnt <= slow_i ? 5'h0C : 5'h01;
            end
            2'h1: if (cnt == 5'h00 && gap == 5'h00) begin
               ack_o <= 1'b1;
               // 14 cycles between acks keeps the word rate under 8 MHz
               gap <= 5'h0D;
               // Slow pass holds the ack far past the strobe
               cnt <= slow_i ? 5'h14 : 5'h03;
               st <= 2'h2;
            end
            default: if (cnt == 5'h00) begin
               ack_o <= 1'b0;
               st <= 2'h0;
            end
         endcase
      end
   end
endmodule : tdc_ecl_driver

// ---- bench/test_tdc_readout.sv ----
// Self-checking bench for mode register, dataway readout and chained front-bus readout
`timescale 1ns/1ps
module test_tdc_readout;
   import tdc_pkg::*;
   localparam logic [3:0] S1 = 4'h8;
   localparam logic [3:0] S2 = 4'h4;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic start_i = 1'b0;
   logic clear_i = 1'b0;
   logic conv_done_i = 1'b0;
   logic slow = 1'b0;
   logic hold = 1'b0;
   logic [7:0] hit_mask_i = 8'h00;
   logic [11:0] conv_code_i = 12'h000;
   tdc_camac_cmd_t camac_i = '0;
   tdc_camac_rsp_t camac_o, rsp;
   logic lam_o, busy_o, chan_start_o, common_stop_o, conv_start_o, ecl_oe_o, word_strobe_o;
   logic word_taken_ack_i, data_pending_flag_o, chain_grant_in_i, chain_grant_out_o, stb_q, ack_q;
   logic [2:0] conv_chan_o;
   logic [2:0] cur_ch = 3'h0;
   logic [2:0] pend = 3'h0;
   logic [11:0] codes [NUM_CH];
   logic [15:0] ecl_data_o, d_q, mode;
   logic [15:0] got [$];
   logic [15:0] exp_q [$];
   int failures = 0;
   int total_checks = 0;
   int seed = 32'h5e4a;
   int hi = 0, lo = 99, since = 99, ndone = 0, n;

   tdc_readout tdc_readout_i (.core_clk_i, .srst_i, .camac_i, .camac_o, .lam_o, .busy_o, .start_i, .clear_i,
      .chan_start_o, .common_stop_o, .hit_mask_i, .conv_start_o, .conv_chan_o, .conv_done_i, .conv_code_i,
      .ecl_data_o, .ecl_oe_o, .word_strobe_o, .word_taken_ack_i, .data_pending_flag_o, .chain_grant_in_i,
      .chain_grant_out_o);
   tdc_ecl_driver tdc_ecl_driver_i (.core_clk_i, .srst_i, .slow_i(slow), .hold_i(hold),
      .word_strobe_i(word_strobe_o), .pending_i(data_pending_flag_o), .grant_out_i(chain_grant_out_o),
      .grant_o(chain_grant_in_i), .ack_o(word_taken_ack_i));

   always #(CLK_NS / 2) core_clk_i = ~core_clk_i;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic complete_run;
      if (failures == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : complete_run

   function automatic logic [15:0] word(input int c);
      return {codes[c] >= OVF_LIMIT && !mode[MB_RANGE_DIS], mode[MB_CHTAG_DIS] ? 3'h0 : 3'(c), codes[c]};
   endfunction : word

   // One dataway cycle; the answer is registered from the command cycle
   task automatic cmd(input logic nn, input logic [4:0] f, input logic [3:0] a, input logic [3:0] ctl,
                      input logic [15:0] w);
      @(posedge core_clk_i);
      camac_i <= {nn, f, a, ctl, 1'b0, w};
      @(posedge core_clk_i);
      camac_i <= '0;
      #1 rsp = camac_o;
   endtask : cmd

   task automatic await(ref logic sig, input logic lvl, input string what, input int lim);
      n = 0;
      while (sig !== lvl && n < lim) begin
         @(posedge core_clk_i);
         #1;
         n++;
      end
      check(what, 16'(sig), 16'(lvl));
   endtask : await

   task automatic set_mode(input logic [15:0] cfg);
      mode = (16'($random(seed)) & 16'h0AFF) | cfg;
      cmd(1'b1, F_WR_MODE, SA_MODE, S1, mode);
      check("mode wr q", 16'(rsp.q), 16'h0001);
      cmd(1'b1, F_RD_MODE, SA_MODE, 4'h0, 16'h0000);
      check("mode rd", rsp.r, mode & MODE_RD_MASK);
   endtask : set_mode

   // Clearing time must pass before the register answers again
   task automatic mode_check(input string what);
      repeat (CLR_CYC + 5) @(posedge core_clk_i);
      cmd(1'b1, F_RD_MODE, SA_MODE, 4'h0, 16'h0000);
      check(what, rsp.r, mode & MODE_RD_MASK);
   endtask : mode_check

   task automatic fill;
      foreach (codes[i]) codes[i] = 12'($random(seed));
      codes[0] = OVF_LIMIT;
      codes[1] = OVF_LIMIT - 12'h001;
   endtask : fill

   task automatic acquire(input logic [7:0] mask);
      fill();
      exp_q.delete();
      got.delete();
      for (int c = 0; c < NUM_CH; c++) if (!mode[MB_SPARSE] || mask[c]) exp_q.push_back(word(c));
      ndone = 0;
      @(posedge core_clk_i);
      hit_mask_i <= mask;
      start_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      start_i <= 1'b0;
   endtask : acquire

   task automatic ready(input logic [3:0] a);
      n = 0;
      do begin
         cmd(1'b1, F_RD_DATA, a, 4'h0, 16'h0000);
         n++;
      end while (!rsp.q && n < 200);
   endtask : ready

   task automatic settle;
      await(busy_o, 1'b0, "busy end", 600);
      repeat (CLR_CYC + 5) @(posedge core_clk_i);
   endtask : settle

   task automatic match;
      check("word count", 16'(got.size()), 16'(exp_q.size()));
      foreach (exp_q[i]) check("bus word", (i < got.size()) ? got[i] : 16'hXXXX, exp_q[i]);
   endtask : match

   // Converter stand-in: answers each request four cycles later
   always @(posedge core_clk_i) begin
      pend <= {pend[1:0], conv_start_o};
      conv_done_i <= pend[2];
      conv_code_i <= codes[cur_ch];
      if (conv_start_o) cur_ch <= conv_chan_o;
      if (pend[2]) ndone <= ndone + 1;
   end

   // Front-bus timing watch; each strobe rise captures the word on the bus
   always @(posedge core_clk_i) begin
      stb_q <= word_strobe_o;
      ack_q <= word_taken_ack_i;
      d_q <= ecl_data_o;
      hi <= word_strobe_o ? hi + 1 : 0;
      lo <= word_strobe_o ? 0 : lo + 1;
      since <= (word_taken_ack_i && !ack_q) ? 0 : since + 1;
      if (word_strobe_o && !stb_q) begin
         check("stb low", 16'(lo >= 6), 16'h0001);
         check("ack gap", 16'(since >= 5), 16'h0001);
         check("ack at stb", 16'(word_taken_ack_i), 16'h0000);
         check("setup", ecl_data_o, d_q);
         got.push_back(ecl_data_o);
      end
      if (word_strobe_o) check("oe", 16'(ecl_oe_o), 16'h0001);
      if (word_strobe_o && stb_q) check("stable", ecl_data_o, got[$]);
      if (!word_strobe_o && stb_q) check("stb width", 16'(hi >= 5), 16'h0001);
   end

   initial begin
      fill();
      repeat (16) @(posedge core_clk_i);
      srst_i <= 1'b0;
      mode = MODE_RESET;
      mode_check("mode reset");
      // Test pulse, addressed mode, LAM on
      set_mode(16'h4000);
      fill();
      cmd(1'b1, F_TEST, SA_ZERO, S2, 16'h0000);
      check("test q", 16'(rsp.q), 16'h0001);
      await(chan_start_o, 1'b1, "test start", 20);
      await(common_stop_o, 1'b1, "test stop", 30);
      await(busy_o, 1'b1, "busy", 300);
      cmd(1'b1, F_TEST, SA_ZERO, S2, 16'h0000);
      check("test busy q", 16'(rsp.q), 16'h0000);
      cmd(1'b1, F_WR_MODE, SA_MODE, S1, 16'h0000);
      check("mode busy q", 16'(rsp.q), 16'h0000);
      ready(SA_LAST);
      check("lam", 16'(lam_o), 16'h0001);
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         cmd(1'b1, (c % 2) ? F_RD_CLR : F_RD_DATA, 4'(c), 4'h0, 16'h0000);
         check("addr word", rsp.r, word(c));
      end
      cmd(1'b1, F_TEST_LAM, SA_ZERO, 4'h0, 16'h0000);
      check("lam test q", 16'(rsp.q), 16'h0001);
      cmd(1'b1, F_CLR_LAM, SA_ZERO, S2, 16'h0000);
      cmd(1'b1, F_TEST_LAM, SA_ZERO, 4'h0, 16'h0000);
      check("lam cleared q", 16'(rsp.q), 16'h0000);
      @(posedge core_clk_i);
      clear_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      clear_i <= 1'b0;
      settle();
      check("lam clr", 16'(lam_o), 16'h0000);
      // Sequential dataway, empty window mask, LAM off
      set_mode(16'h2000);
      acquire(8'h00);
      ready(SA_ZERO);
      check("lam off", 16'(lam_o), 16'h0000);
      foreach (exp_q[i]) begin
         cmd(1'b1, F_RD_DATA, SA_ZERO, S2, 16'h0000);
         check("seq word", rsp.r, exp_q[i]);
      end
      settle();
      check("no strobes", 16'(got.size()), 16'h0000);
      // Front bus, sparse, quick driver
      set_mode(16'h7400);
      acquire(8'($random(seed)) | 8'h81);
      await(data_pending_flag_o, 1'b1, "pending", 400);
      cmd(1'b1, F_RD_DATA, SA_ZERO, 4'h0, 16'h0000);
      check("dataway q", 16'(rsp.q), 16'h0000);
      check("lam front", 16'(lam_o), 16'h0000);
      await(data_pending_flag_o, 1'b0, "pending end", 800);
      await(chain_grant_out_o, 1'b1, "pass", 20);
      match();
      settle();
      // Front bus with grant already passing, slow and held acks
      slow <= 1'b1;
      hold <= 1'b1;
      set_mode(16'h2400);
      acquire(8'h00);
      n = 0;
      while (ndone < NUM_CH && n < 600) begin
         @(posedge core_clk_i);
         n++;
      end
      repeat (5) @(posedge core_clk_i);
      check("pend held", 16'(data_pending_flag_o), 16'h0000);
      check("pass idle", 16'(chain_grant_out_o), 16'h0001);
      hold <= 1'b0;
      await(data_pending_flag_o, 1'b1, "pend late", 50);
      await(data_pending_flag_o, 1'b0, "pend end", 2000);
      match();
      settle();
      // Initialize sets the mode bits, a plain clear leaves them
      cmd(1'b0, 5'h00, SA_ZERO, 4'h6, 16'h0000);
      mode = mode | MODE_INIT_SET;
      mode_check("mode init");
      cmd(1'b1, F_CLEAR, SA_ZERO, S2, 16'h0000);
      mode_check("mode clr");
      complete_run();
   end

   initial begin
      #(40000 * CLK_NS);
      failures++;
      complete_run();
   end
endmodule : test_tdc_readout
